/* File: hw/tcp_pkg.sv */
// Package for the core test control port: register map, field positions, reset values.
// Assumes a 32-bit AXI4-Lite register bus on a single 100 MHz clock.
package tcp_pkg;

  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;

  // Register byte offsets.
  localparam logic [7:0] OFS_CTRL      = 8'h00;
  localparam logic [7:0] OFS_STATUS    = 8'h04;
  localparam logic [7:0] OFS_LANE_REQ  = 8'h08;
  localparam logic [7:0] OFS_DEBUG     = 8'h0C;

  // Control word fields.
  localparam int unsigned CTL_SIM      = 0;
  localparam int unsigned CTL_RSV_LO   = 1;
  localparam int unsigned CTL_RSV_HI   = 4;
  localparam int unsigned CTL_COMPL    = 5;
  localparam int unsigned CTL_HI_LO    = 6;
  localparam int unsigned CTL_HI_HI    = 31;

  // Fixed patterns the control word must carry in its reserved fields.
  localparam logic [3:0]  CTL_RSV_VAL  = 4'h8;
  localparam logic [25:0] CTL_HI_VAL   = 26'h0000002;
  localparam logic [31:0] CTRL_RESET   = {CTL_HI_VAL, 1'b0, CTL_RSV_VAL, 1'b0};

  // Status word fields.
  localparam int unsigned ST_PIPE_SIM  = 0;
  localparam int unsigned ST_COMPL     = 1;
  localparam int unsigned ST_RSV_BAD   = 2;
  localparam int unsigned ST_LANE_LO   = 4;

  // One-hot lane counts, and the all-zero value held before training.
  localparam logic [3:0] LANE_X1       = 4'h1;
  localparam logic [3:0] LANE_X2       = 4'h2;
  localparam logic [3:0] LANE_X4       = 4'h4;
  localparam logic [3:0] LANE_X8       = 4'h8;
  localparam logic [3:0] LANE_RESET    = 4'h0;

  // AXI response codes.
  localparam logic [1:0] RESP_OKAY     = 2'h0;
  localparam logic [1:0] RESP_SLVERR   = 2'h2;

  // Link training summary states.
  typedef enum logic [1:0] {
    TCP_DETECT = 2'b00,
    TCP_TRAIN  = 2'b01,
    TCP_UP     = 2'b11,
    TCP_COMPL  = 2'b10
  } tcp_ltssm_t;

endpackage

/* File: hw/tcp_link_if.sv */
// Interface carrying control and status between the test port and its link model.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface tcp_link_if;
  logic       sim_mode;
  logic       compl_toggle;
  logic [3:0] lane_req;
  logic       pipe_sim;
  logic       in_compl;
  logic [3:0] lane_act;

  modport port (output sim_mode, output compl_toggle, output lane_req,
                input pipe_sim, input in_compl, input lane_act);
  modport link (input sim_mode, input compl_toggle, input lane_req,
                output pipe_sim, output in_compl, output lane_act);
endinterface

/* File: hw/tcp_link.sv */
// Simplified link training summary used behind the test control port.
// Assumes a single clock; clock enable freezes all state.
`timescale 1ns/1ps
module tcp_link (
  input  wire logic  aclk,
  input  wire logic  aresetn,
  input  wire logic  ce,
  tcp_link_if.link   lnk
);
  import tcp_pkg::*;

  tcp_ltssm_t state_q;
  tcp_ltssm_t state_d;
  logic [3:0] lane_q;
  logic [3:0] lane_d;
  logic       sim_q;

  // Compliance is entered and left only on a toggle, never on its own.
  // no entry unless toggled
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      TCP_DETECT: state_d = TCP_TRAIN;
      TCP_TRAIN:  state_d = lnk.compl_toggle ? TCP_COMPL : TCP_UP;
      TCP_UP:     state_d = lnk.compl_toggle ? TCP_COMPL : TCP_UP;
      TCP_COMPL:  state_d = lnk.compl_toggle ? TCP_UP : TCP_COMPL;
    endcase
  end

  // Only a legal one-hot request is accepted; anything else trains one lane.
  assign lane_d = (lnk.lane_req == LANE_X2 || lnk.lane_req == LANE_X4 || lnk.lane_req == LANE_X8)
                  ? lnk.lane_req : LANE_X1;

  // State, trained width and simulation flag.
  // The width is latched once per training, so later requests wait for the next reset.
  // latch trained width
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= TCP_DETECT;
      lane_q  <= LANE_RESET;
      sim_q   <= 1'b0;
    end else if (ce) begin
      state_q <= state_d;
      sim_q   <= lnk.sim_mode;
      if (state_q == TCP_TRAIN) begin
        lane_q <= lane_d;
      end
    end
  end

  assign lnk.pipe_sim = sim_q;
  assign lnk.in_compl = (state_q == TCP_COMPL);
  assign lnk.lane_act = lane_q;
endmodule

/* File: hw/tcp_top.sv */
// Test control port of the protocol core with an AXI4-Lite register slave.
// Assumes AXI4-Lite master on aclk; user logic only reads status for display.
//
// Notes on behaviour
// - Control bit 0 high selects simulation mode with shortened initialization counters; the link model has no counters, it only sets the PIPE simulation flag.
// - While control bit 5 is set, training cannot enter compliance.
// - Toggling control bit 5 enters or leaves the compliance pattern state.
// - PIPE simulation status reads 1 exactly while the interface runs simulation mode.
// - Trained lane count is reported one-hot: 0001, 0010, 0100 or 1000.
// - The debug output word carries no information and always reads zero.
//
// Chosen here: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module tcp_top (
  input  wire logic                    aclk,
  input  wire logic                    aresetn,
  input  wire logic                    ce,
  input  wire logic [tcp_pkg::ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                    s_axi_awvalid,
  output logic                         s_axi_awready,
  input  wire logic [31:0]             s_axi_wdata,
  input  wire logic [3:0]              s_axi_wstrb,
  input  wire logic                    s_axi_wvalid,
  output logic                         s_axi_wready,
  output logic [1:0]                   s_axi_bresp,
  output logic                         s_axi_bvalid,
  input  wire logic                    s_axi_bready,
  input  wire logic [tcp_pkg::ADDR_W-1:0] s_axi_araddr,
  input  wire logic                    s_axi_arvalid,
  output logic                         s_axi_arready,
  output logic [31:0]                  s_axi_rdata,
  output logic [1:0]                   s_axi_rresp,
  output logic                         s_axi_rvalid,
  input  wire logic                    s_axi_rready,
  output logic                         pipe_sim_q,
  output logic [3:0]                   lane_act_q,
  output logic [31:0]                  debug_out_q
);
  import tcp_pkg::*;

  tcp_link_if lnk ();

  logic [31:0] ctrl_q;
  logic [3:0]  lane_req_q;
  logic        compl_prev_q;
  logic        aw_got_q;
  logic        w_got_q;
  logic [7:0]  awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0]  wstrb_q;

  // Byte-enable merge, used by both writable registers.
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) r[i*8 +: 8] = nw[i*8 +: 8];
    end
    return r;
  endfunction

  // Write handshake: address and data are captured separately, in either order.
  wire        aw_take   = s_axi_awvalid && s_axi_awready;
  wire        w_take    = s_axi_wvalid && s_axi_wready;
  wire        aw_have   = aw_got_q || aw_take;
  wire        w_have    = w_got_q || w_take;
  wire [7:0]  wr_addr   = aw_got_q ? awaddr_q : s_axi_awaddr;
  wire [31:0] wr_data   = w_got_q ? wdata_q : s_axi_wdata;
  wire [3:0]  wr_strb   = w_got_q ? wstrb_q : s_axi_wstrb;
  wire        wr_fire   = aw_have && w_have && !s_axi_bvalid;
  wire        wr_ctrl   = wr_fire && (wr_addr == OFS_CTRL);
  wire        wr_lane   = wr_fire && (wr_addr == OFS_LANE_REQ);
  wire        wr_ok     = (wr_addr == OFS_CTRL) || (wr_addr == OFS_LANE_REQ);
  wire [31:0] ctrl_new  = merge(ctrl_q, wr_data, wr_strb);
  wire [31:0] lane_new  = merge({28'h0000000, lane_req_q}, wr_data, wr_strb);

  // Read decode of the status word and the register file.
  wire        rsv_bad   = (ctrl_q[CTL_RSV_HI:CTL_RSV_LO] != CTL_RSV_VAL) ||
                          (ctrl_q[CTL_HI_HI:CTL_HI_LO] != CTL_HI_VAL);
  wire [31:0] status_w  = {24'h000000, lnk.lane_act, 1'b0, rsv_bad, lnk.in_compl, lnk.pipe_sim};
  wire        rd_ok     = (s_axi_araddr == OFS_CTRL) || (s_axi_araddr == OFS_STATUS) ||
                          (s_axi_araddr == OFS_LANE_REQ) || (s_axi_araddr == OFS_DEBUG);
  wire [31:0] rd_word   = (s_axi_araddr == OFS_CTRL)     ? ctrl_q :
                          (s_axi_araddr == OFS_STATUS)   ? status_w :
                          (s_axi_araddr == OFS_LANE_REQ) ? {28'h0000000, lane_req_q} :
                          32'h00000000;

  // Link-side drive: bit 0 selects simulation mode.
  // simulation mode select
  assign lnk.sim_mode     = ctrl_q[CTL_SIM];
  // A toggle is a set-then-clear pulse of bit 5. Acting only on the clear keeps a set bit from entering.
  // toggle pulse switches
  assign lnk.compl_toggle = compl_prev_q && !ctrl_q[CTL_COMPL];
  assign lnk.lane_req     = lane_req_q;

  tcp_link u_link (
    .aclk    (aclk),
    .aresetn (aresetn),
    .ce      (ce),
    .lnk     (lnk)
  );

  // Control register and the edge memory of the compliance bit.
  // Reset loads the mandated reserved patterns so software need not rewrite them.
  // reserved pattern 1000
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q       <= CTRL_RESET;
      lane_req_q   <= LANE_X8;
      compl_prev_q <= 1'b0;
    end else if (ce) begin
      compl_prev_q <= ctrl_q[CTL_COMPL];
      if (wr_ctrl) ctrl_q <= ctrl_new;
      if (wr_lane) lane_req_q <= lane_new[3:0];
    end
  end

  // Write channel state: a taken half is held until the pair completes.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_q      <= 1'b0;
      w_got_q       <= 1'b0;
      awaddr_q      <= 8'h00;
      wdata_q       <= 32'h00000000;
      wstrb_q       <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
    end else if (ce) begin
      if (aw_take) awaddr_q <= s_axi_awaddr;
      if (w_take) begin
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      aw_got_q      <= aw_have && !wr_fire;
      w_got_q       <= w_have && !wr_fire;
      s_axi_awready <= !aw_have && !s_axi_bvalid && !wr_fire;
      s_axi_wready  <= !w_have && !s_axi_bvalid && !wr_fire;
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Read channel: one cycle from address acceptance to data.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= RESP_OKAY;
    end else if (ce) begin
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_word;
        s_axi_rresp  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Status pins mirror the link state, registered for clean display use.
  // Display only; these are not meant to steer functional logic.
  // PIPE simulation flag
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pipe_sim_q  <= 1'b0;
      lane_act_q  <= LANE_RESET;
      debug_out_q <= 32'h00000000;
    end else if (ce) begin
      pipe_sim_q  <= lnk.pipe_sim;
      lane_act_q  <= lnk.lane_act;
      debug_out_q <= 32'h00000000;
    end
  end
endmodule

/* File: tb/tcp_chk_sva.sv */
// Checker for the test control port, watching only the top module's pins.
// Assumes one clock domain and a synchronous active-low reset.
`timescale 1ns/1ps
module tcp_chk
  import tcp_pkg::*;
(
  input wire logic                       aclk,
  input wire logic                       aresetn,
  input wire logic                       ce,
  input wire logic                       s_axi_awvalid,
  input wire logic                       s_axi_awready,
  input wire logic                       s_axi_bvalid,
  input wire logic [tcp_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic                       s_axi_arvalid,
  input wire logic                       s_axi_arready,
  input wire logic [31:0]                s_axi_rdata,
  input wire logic [1:0]                 s_axi_rresp,
  input wire logic                       s_axi_rvalid,
  input wire logic                       s_axi_rready,
  input wire logic [3:0]                 lane_act_q,
  input wire logic [31:0]                debug_out_q
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // Decode of the four mapped words; anything else must be refused.
  wire rd_map = s_axi_araddr inside {OFS_CTRL, OFS_STATUS, OFS_LANE_REQ, OFS_DEBUG};
  wire rd_take = s_axi_arvalid && s_axi_arready && ce;

  chk_debug_zero: assert property (debug_out_q == 32'h0)
    else $error("debug word not zero");
  chk_lane_onehot: assert property ($onehot0(lane_act_q))
    else $error("lane count not one-hot");
  chk_lane_held: assert property (lane_act_q != 4'h0 |=> $stable(lane_act_q))
    else $error("trained lane count moved");
  chk_rd_answer: assert property (rd_take |=> s_axi_rvalid)
    else $error("read answer late");
  chk_rd_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped before rready");
  chk_rd_block: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("arready high while read pending");
  chk_wr_block: assert property (s_axi_bvalid |-> !s_axi_awready)
    else $error("awready high while write response pending");
  chk_wr_answer: assert property (s_axi_awvalid && s_axi_awready && ce |-> ##[1:4] s_axi_bvalid)
    else $error("write response missing");
  chk_rd_refused: assert property (rd_take && !rd_map |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");

  // Main scenarios the bench should reach.
  cov_read: cover property (rd_take);
  cov_refused: cover property (rd_take && !rd_map);
  cov_trained: cover property (lane_act_q == LANE_X8);
endmodule

bind tcp_top tcp_chk tcp_chk_i (.aclk(aclk), .aresetn(aresetn), .ce(ce), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_bvalid(s_axi_bvalid), .s_axi_araddr(s_axi_araddr),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .lane_act_q(lane_act_q), .debug_out_q(debug_out_q));

/* File: tb/tcp_led_mon.sv */
// User-side monitor that turns the lane count status pins into display lights.
// Assumes it shares the port's clock; it never feeds anything back.
`timescale 1ns/1ps
module tcp_led_mon (
  input  wire logic       aclk,
  input  wire logic [3:0] lane_act,
  output logic      [3:0] leds_q
);
  always_ff @(posedge aclk) begin
    leds_q <= lane_act;
  end
endmodule

/* File: tb/tb.sv */
// Bench for the test control port: AXI4-Lite tasks, pin and register checks.
// Assumes the design's reset values and its status delays of a few cycles.
`timescale 1ns/1ps
module tb;
  import tcp_pkg::*;
  logic        aclk, aresetn, ce, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid, pipe_sim;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, dbg, d;
  logic [3:0]  wstrb, lane, leds;
  logic [1:0]  bresp, rresp, r;
  int          n_errors = 0;
  int          compares = 0;

  tcp_top tcp_top_i (.aclk(aclk), .aresetn(aresetn), .ce(ce), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .pipe_sim_q(pipe_sim),
    .lane_act_q(lane), .debug_out_q(dbg));
  tcp_led_mon tcp_led_mon_i (.aclk(aclk), .lane_act(lane), .leds_q(leds));

  // Free-running 100 MHz clock.
  initial begin
    aclk = 1'h0;
    forever #5 aclk = ~aclk;
  end

  task automatic stop_test;
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Write: both halves offered together, each dropped once taken, bready held until bvalid.
  task automatic wrc(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
    @(posedge aclk);
    awaddr <= a; awvalid <= 1'h1; wdata <= v; wstrb <= 4'hF; wvalid <= 1'h1; bready <= 1'h1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
    end while (!bvalid);
    bready <= 1'h0;
    chk("write resp", {30'h0, bresp}, {30'h0, er});
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a; arvalid <= 1'h1; rready <= 1'h1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'h0;
    end while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'h0;
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] ev, input logic [1:0] er, input string nm);
    rd(a);
    chk(nm, d, ev);
    chk("read resp", {30'h0, r}, {30'h0, er});
  endtask

  // The tests take well under 1000 cycles, so 5000 means a hang.
  initial begin
    repeat (5000) @(posedge aclk);
    n_errors++;
    $display("watchdog expired");
    stop_test;
  end

  logic [3:0]  codes [4] = '{LANE_X1, LANE_X2, LANE_X4, LANE_X8};
  logic [31:0] cw [5] = '{32'hB0, 32'hB0, 32'h90, 32'hB0, 32'h90};
  logic [4:0]  cx = 5'h06;
  logic [31:0] rw [3] = '{32'h80, 32'h10, 32'h90};
  logic [2:0]  rx = 3'h6;

  initial begin
    {aresetn, ce, awvalid, wvalid, bready, arvalid, rready} = 7'h20;
    {awaddr, araddr, wdata, wstrb} = 52'h0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'h1;
    repeat (10) @(posedge aclk);
    rdc(OFS_CTRL, CTRL_RESET, RESP_OKAY, "ctrl reset");
    rdc(OFS_STATUS, {24'h0, LANE_X8, 4'h0}, RESP_OKAY, "status reset");
    chk("lane pin", {28'h0, lane}, {28'h0, LANE_X8});
    chk("leds", {28'h0, leds}, {28'h0, LANE_X8});
    $display("test reset done");
    foreach (codes[i]) begin
      wrc(OFS_LANE_REQ, {28'h0, codes[i]}, RESP_OKAY);
      rdc(OFS_LANE_REQ, {28'h0, codes[i]}, RESP_OKAY, "lane req");
    end
    $display("test lanes done");
    // Simulation mode on, then off again.
    wrc(OFS_CTRL, CTRL_RESET | 32'h1, RESP_OKAY);
    repeat (4) @(posedge aclk);
    chk("pipe sim on", {31'h0, pipe_sim}, 32'h1);
    wrc(OFS_CTRL, CTRL_RESET, RESP_OKAY);
    repeat (4) @(posedge aclk);
    chk("pipe sim off", {31'h0, pipe_sim}, 32'h0);
    $display("test sim mode done");
    // Setting bit 5 never enters compliance; each clear that ends a pulse switches it in or out.
    // only bit 5 changes here
    foreach (cw[i]) begin
      wrc(OFS_CTRL, cw[i], RESP_OKAY);
      repeat (4) @(posedge aclk);
      rd(OFS_STATUS);
      chk("compliance", {31'h0, d[ST_COMPL]}, {31'h0, cx[4-i]});
    end
    $display("test compliance done");
    foreach (rw[i]) begin
      wrc(OFS_CTRL, rw[i], RESP_OKAY);
      rd(OFS_STATUS);
      chk("reserved bad", {31'h0, d[ST_RSV_BAD]}, {31'h0, rx[2-i]});
    end
    $display("test reserved done");
    wrc(8'h20, 32'hFFFFFFFF, RESP_SLVERR);
    rdc(8'h20, 32'h0, RESP_SLVERR, "unmapped");
    rdc(OFS_DEBUG, 32'h0, RESP_OKAY, "debug reg");
    chk("debug pin", dbg, 32'h0);
    $display("test refusals done");
    stop_test;
  end
endmodule
